// ===== design/eight_bit_match_timer.sv
// Design decisions made here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "match_timer_cfg.svh"

module eight_bit_match_timer #(
  parameter int ICKS_BIT = 0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // pins
  input wire logic ext_count_clock_in_i,
  input wire logic ext_reset_in_i,
  output logic timer_output_pin_o,
  // interrupt requests
  output logic match_irq_a_o,
  output logic match_irq_b_o,
  output logic overflow_irq_o
);

  // registers
  logic [7:0] timer_control_q, timer_control_d;
  logic [3:0] output_select_q, output_select_d;
  logic [1:0] serial_timer_control_q, serial_timer_control_d;
  logic [7:0] match_constant_a_q, match_constant_a_d;
  logic [7:0] match_constant_b_q, match_constant_b_d;
  logic [7:0] timer_count_q, timer_count_d;
  logic match_flag_a_q, match_flag_a_d;
  logic match_flag_b_q, match_flag_b_d;
  logic overflow_flag_q, overflow_flag_d;
  logic [2:0] armed_q, armed_d;
  logic out_q, out_d;
  logic [`PRESCALER_WIDTH-1:0] prescale_q, prescale_d;
  logic src_prev_q, src_prev_d;
  logic ext_clk_s1_q, ext_clk_s2_q, ext_rst_s1_q, ext_rst_s2_q, ext_rst_prev_q;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic irq_a_q, irq_a_d, irq_b_q, irq_b_d, irq_ovf_q, irq_ovf_d;

  // selected source level; stopped reads as low
  function automatic logic src_level(input logic [2:0] cks, input logic icks,
                                     input logic [`PRESCALER_WIDTH-1:0] pre,
                                     input logic ext);
    logic lvl;
    lvl = 1'b0;
    case (cks)
      3'h1: lvl = icks ? pre[`TAP_DIV2] : pre[`TAP_DIV8];
      3'h2: lvl = icks ? pre[`TAP_DIV128] : pre[`TAP_DIV64];
      3'h3: lvl = icks ? pre[`TAP_DIV2048] : pre[`TAP_DIV1024];
      3'h5, 3'h6, 3'h7: lvl = ext;
      default: lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  function automatic logic apply_act(input logic cur, input logic [1:0] act);
    logic r;
    r = cur;
    case (match_timer_pkg::out_act_t'(act))
      match_timer_pkg::OUT_LOW: r = 1'b0;
      match_timer_pkg::OUT_HIGH: r = 1'b1;
      match_timer_pkg::OUT_TOGGLE: r = ~cur;
      default: r = cur;
    endcase
    return r;
  endfunction

  logic [2:0] cks;
  logic cur_lvl, inc, match_a, match_b, clr, ext_rst_rise;
  logic bus_req, wr_fire, rd_fire;
  logic [1:0] act;
  logic [7:0] status_rd;
  match_timer_pkg::clear_sel_t clr_sel;

  always_comb begin
    cks = timer_control_q[`TC_CKS_LSB +: 3];
    clr_sel = match_timer_pkg::clear_sel_t'(timer_control_q[`TC_CLR_LSB +: 2]);
    prescale_d = prescale_q + 1'b1;
    cur_lvl = src_level(cks, serial_timer_control_q[ICKS_BIT], prescale_q, ext_clk_s2_q);
    src_prev_d = cur_lvl;
    inc = 1'b0;
    // edge of the unified source level; a select change also forms an edge
    case (cks)
      3'h5: inc = ~src_prev_q & cur_lvl; // RULE3 RULE19
      3'h7: inc = src_prev_q ^ cur_lvl; // RULE3
      default: inc = src_prev_q & ~cur_lvl; // RULE2 RULE18 RULE20 RULE19
    endcase
    ext_rst_rise = ext_rst_s2_q & ~ext_rst_prev_q;
    // bus: ack one cycle after request; write lands in the ack cycle
    bus_req = cyc_i & stb_i;
    ack_d = bus_req & ~ack_q;
    wr_fire = bus_req & we_i & ack_q & sel_i[0];
    rd_fire = bus_req & ~we_i & ack_q;
    status_rd = {match_flag_b_q, match_flag_a_q, overflow_flag_q, 1'b1, output_select_q};
    dat_d = 32'h0;
    if (bus_req & ~ack_q) begin
      case (adr_i)
        `REG_TIMER_CONTROL: dat_d = {24'h0, timer_control_q};
        `REG_TIMER_STATUS_CONTROL: dat_d = {24'h0, status_rd};
        `REG_MATCH_CONSTANT_A: dat_d = {24'h0, match_constant_a_q};
        `REG_MATCH_CONSTANT_B: dat_d = {24'h0, match_constant_b_q};
        `REG_TIMER_COUNT: dat_d = {24'h0, timer_count_q};
        `REG_SERIAL_TIMER_CONTROL: dat_d = {30'h0, serial_timer_control_q};
        default: dat_d = 32'h0;
      endcase
    end
    // match in the last state of the value, suppressed by a constant write
    match_a = inc & (timer_count_q == match_constant_a_q) &
              ~(wr_fire & (adr_i == `REG_MATCH_CONSTANT_A)); // RULE5 RULE16
    match_b = inc & (timer_count_q == match_constant_b_q) &
              ~(wr_fire & (adr_i == `REG_MATCH_CONSTANT_B)); // RULE5 RULE16
    clr = 1'b0;
    case (clr_sel)
      match_timer_pkg::CLR_ON_A: clr = match_a; // RULE7 RULE13
      match_timer_pkg::CLR_ON_B: clr = match_b; // RULE7
      match_timer_pkg::CLR_EXT: clr = ext_rst_rise; // RULE8
      default: clr = 1'b0;
    endcase
    // count: clear beats write, write beats increment
    timer_count_d = timer_count_q;
    if (clr) begin
      timer_count_d = 8'h00; // RULE14
    end else if (wr_fire & (adr_i == `REG_TIMER_COUNT)) begin
      timer_count_d = dat_i[7:0]; // RULE15
    end else if (inc) begin
      timer_count_d = timer_count_q + 8'h01; // RULE1 RULE24
    end
    // output: larger code wins, matching toggle > high > low > keep
    act = 2'h0;
    if (match_a) begin
      act = output_select_q[`TSC_OS_A_LSB +: 2]; // RULE22
    end
    if (match_b && output_select_q[`TSC_OS_B_LSB +: 2] > act) begin
      act = output_select_q[`TSC_OS_B_LSB +: 2]; // RULE17 RULE22
    end
    out_d = (match_a | match_b) ? apply_act(out_q, act) : out_q; // RULE6 RULE13
    // register writes
    timer_control_d = timer_control_q;
    output_select_d = output_select_q;
    serial_timer_control_d = serial_timer_control_q;
    match_constant_a_d = match_constant_a_q;
    match_constant_b_d = match_constant_b_q;
    match_flag_a_d = match_flag_a_q;
    match_flag_b_d = match_flag_b_q;
    overflow_flag_d = overflow_flag_q;
    armed_d = armed_q;
    if (rd_fire && adr_i == `REG_TIMER_STATUS_CONTROL) begin
      armed_d = armed_q | {match_flag_b_q, match_flag_a_q, overflow_flag_q}; // RULE21
    end
    if (wr_fire) begin
      case (adr_i)
        `REG_TIMER_CONTROL: timer_control_d = dat_i[7:0];
        `REG_MATCH_CONSTANT_A: match_constant_a_d = dat_i[7:0];
        `REG_MATCH_CONSTANT_B: match_constant_b_d = dat_i[7:0];
        `REG_SERIAL_TIMER_CONTROL: serial_timer_control_d = dat_i[1:0];
        `REG_TIMER_STATUS_CONTROL: begin
          output_select_d = dat_i[3:0];
          // only a zero after a read of the set flag clears it
          if (armed_q[2] & ~dat_i[`TSC_MATCH_B]) begin
            match_flag_b_d = 1'b0; // RULE21
          end
          if (armed_q[1] & ~dat_i[`TSC_MATCH_A]) begin
            match_flag_a_d = 1'b0; // RULE21
          end
          if (armed_q[0] & ~dat_i[`TSC_OVF]) begin
            overflow_flag_d = 1'b0; // RULE21
          end
          armed_d = 3'h0;
        end
        default: ;
      endcase
    end
    // hardware set wins over software clear
    if (match_a) begin
      match_flag_a_d = 1'b1; // RULE5
    end
    if (match_b) begin
      match_flag_b_d = 1'b1; // RULE5
    end
    if (inc & ~clr & ~(wr_fire & (adr_i == `REG_TIMER_COUNT)) & (timer_count_q == 8'hff)) begin
      overflow_flag_d = 1'b1; // RULE10
    end
    irq_a_d = match_flag_a_d & timer_control_d[`TC_IRQ_EN_A]; // RULE11 RULE12
    irq_b_d = match_flag_b_d & timer_control_d[`TC_IRQ_EN_B]; // RULE11 RULE12
    irq_ovf_d = overflow_flag_d & timer_control_d[`TC_IRQ_EN_OVF]; // RULE11 RULE12
  end

  always_ff @(posedge clk_i) begin
    // pin synchronisers
    ext_clk_s1_q <= ext_count_clock_in_i;
    ext_clk_s2_q <= ext_clk_s1_q;
    ext_rst_s1_q <= ext_reset_in_i;
    ext_rst_s2_q <= ext_rst_s1_q;
    if (rst_i) begin
      timer_control_q <= `TIMER_CONTROL_RST;
      output_select_q <= `OUTPUT_SELECT_RST;
      serial_timer_control_q <= `SERIAL_TIMER_CONTROL_RST;
      match_constant_a_q <= `MATCH_CONSTANT_RST;
      match_constant_b_q <= `MATCH_CONSTANT_RST;
      timer_count_q <= `TIMER_COUNT_RST; // RULE24
      match_flag_a_q <= 1'b0;
      match_flag_b_q <= 1'b0;
      overflow_flag_q <= 1'b0;
      armed_q <= 3'h0;
      out_q <= 1'b0; // RULE23
      prescale_q <= '0;
      src_prev_q <= 1'b0;
      ext_rst_prev_q <= 1'b0;
      ack_q <= 1'b0;
      dat_q <= 32'h0;
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      irq_ovf_q <= 1'b0;
    end else begin
      timer_control_q <= timer_control_d;
      output_select_q <= output_select_d;
      serial_timer_control_q <= serial_timer_control_d;
      match_constant_a_q <= match_constant_a_d;
      match_constant_b_q <= match_constant_b_d;
      timer_count_q <= timer_count_d;
      match_flag_a_q <= match_flag_a_d;
      match_flag_b_q <= match_flag_b_d;
      overflow_flag_q <= overflow_flag_d;
      armed_q <= armed_d;
      out_q <= out_d;
      prescale_q <= prescale_d;
      src_prev_q <= src_prev_d;
      ext_rst_prev_q <= ext_rst_s2_q;
      ack_q <= ack_d;
      dat_q <= dat_d;
      irq_a_q <= irq_a_d;
      irq_b_q <= irq_b_d;
      irq_ovf_q <= irq_ovf_d;
    end
  end

  assign dat_o = dat_q;
  assign ack_o = ack_q;
  assign timer_output_pin_o = out_q;
  assign match_irq_a_o = irq_a_q;
  assign match_irq_b_o = irq_b_q;
  assign overflow_irq_o = irq_ovf_q;

endmodule

// ===== design/match_timer_cfg.svh
// Function
// (RULE1) count advances one per selected source period; the both-edge external mode advances twice per period
// (RULE2) internal count on falling edge of prescaler tap
// (RULE3) external clock counts rising, falling or both
// (RULE4) external clock pulses at least 1.5/2.5 cycles
// (RULE5) match pulse in last state before increment
// (RULE6) match drives output: keep, low, high, toggle
// (RULE7) clear count on match a or b
// (RULE8) clear select 11 uses external reset edge
// (RULE9) external reset pulse at least 1.5 cycles
// (RULE10) overflow flag set on ff to 00 wrap
// (RULE11) three interrupt requests, one per flag
// (RULE12) each interrupt gated by own enable bit
// (RULE13) select 0110 gives software-free pulse train
// (RULE14) clear beats cpu count write
// (RULE15) cpu count write beats increment
// (RULE16) constant write suppresses coinciding match
// (RULE17) simultaneous matches: toggle, high, low, none
// (RULE18) tap change high to low counts once
// (RULE19) internal/external switch may count once
// (RULE20) stopped source counts as low level
// (RULE21) flags cleared by read-then-write-zero only
// (RULE22) output select 2-bit codes, b high, a low
// (RULE23) output low after reset until first match
// (RULE24) count is 8 bits, reset zero, wraps
`ifndef MATCH_TIMER_CFG_SVH
`define MATCH_TIMER_CFG_SVH

// register word offsets (byte addresses)
`define REG_TIMER_CONTROL 8'h00
`define REG_TIMER_STATUS_CONTROL 8'h04
`define REG_MATCH_CONSTANT_A 8'h08
`define REG_MATCH_CONSTANT_B 8'h0c
`define REG_TIMER_COUNT 8'h10
`define REG_SERIAL_TIMER_CONTROL 8'h14

// timer_control fields
`define TC_IRQ_EN_B 7
`define TC_IRQ_EN_A 6
`define TC_IRQ_EN_OVF 5
`define TC_CLR_LSB 3
`define TC_CKS_LSB 0

// timer_status_control fields
`define TSC_MATCH_B 7
`define TSC_MATCH_A 6
`define TSC_OVF 5
`define TSC_FIXED_ONE 4
`define TSC_OS_B_LSB 2
`define TSC_OS_A_LSB 0

// reset values
`define TIMER_CONTROL_RST 8'h00
`define OUTPUT_SELECT_RST 4'h0
`define SERIAL_TIMER_CONTROL_RST 2'h0
`define MATCH_CONSTANT_RST 8'hff
`define TIMER_COUNT_RST 8'h00

// prescaler tap bit positions for /2 /8 /64 /128 /1024 /2048
`define TAP_DIV2 0
`define TAP_DIV8 2
`define TAP_DIV64 5
`define TAP_DIV128 6
`define TAP_DIV1024 9
`define TAP_DIV2048 10
`define PRESCALER_WIDTH 11

`endif

// ===== design/match_timer_pkg.sv
package match_timer_pkg;

  typedef enum logic [1:0] {
    OUT_KEEP,
    OUT_LOW,
    OUT_HIGH,
    OUT_TOGGLE
  } out_act_t;

  typedef enum logic [1:0] {
    CLR_NONE,
    CLR_ON_A,
    CLR_ON_B,
    CLR_EXT
  } clear_sel_t;

endpackage

// ===== verif/eight_bit_match_timer_monitor.sv
`timescale 1ns/1ps
module match_timer_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic timer_output_pin_o,
  input wire logic match_irq_a_o,
  input wire logic match_irq_b_o,
  input wire logic overflow_irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_dat_upper; ack_o |-> dat_o[31:8] == 24'h0; endproperty
  a_dat_upper: assert property (p_dat_upper) else $error("read upper bits set");
  property p_fall_a; $fell(match_irq_a_o) |-> $past(ack_o && we_i); endproperty
  a_fall_a: assert property (p_fall_a) else $error("irq a fell alone");
  property p_fall_b; $fell(match_irq_b_o) |-> $past(ack_o && we_i); endproperty
  a_fall_b: assert property (p_fall_b) else $error("irq b fell alone");
  property p_fall_ovf; $fell(overflow_irq_o) |-> $past(ack_o && we_i); endproperty
  a_fall_ovf: assert property (p_fall_ovf) else $error("irq ovf fell alone");
  property p_pin_rst; $fell(rst_i) |-> !timer_output_pin_o; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin high at reset");
  property p_irq_rst; $fell(rst_i) |-> !(match_irq_a_o | match_irq_b_o | overflow_irq_o); endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq high at reset");
endmodule
bind eight_bit_match_timer match_timer_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .dat_o, .ack_o, .timer_output_pin_o, .match_irq_a_o, .match_irq_b_o, .overflow_irq_o);

// ===== verif/ext_source_model.sv
`timescale 1ns/1ps
module ext_source_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [3:0] edges_i,
  input wire logic pulse_rst_i,
  output logic ext_clk_o,
  output logic ext_rst_o,
  output logic busy_o
);
  logic [3:0] left_q = 4'h0;
  logic [1:0] div_q = 2'h0;
  logic [1:0] rst_q = 2'h0;
  initial ext_clk_o = 1'b0;
  // reset pulse held three cycles
  assign ext_rst_o = rst_q != 2'h0;
  assign busy_o = left_q != 4'h0 || rst_q != 2'h0;
  always @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    if (go_i) begin
      left_q <= edges_i;
      div_q <= 2'h0;
    end else if (left_q != 4'h0 && div_q == 2'h3) begin
      // each level held four cycles
      ext_clk_o <= !ext_clk_o;
      left_q <= left_q - 4'h1;
    end
    if (pulse_rst_i) rst_q <= 2'h3;
    else if (rst_q != 2'h0) rst_q <= rst_q - 2'h1;
  end
endmodule

// ===== verif/tb_eight_bit_match_timer.sv
`timescale 1ns/1ps
module tb_eight_bit_match_timer;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0, edges = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic ack_o, pin, irq_a, irq_b, irq_ovf, ext_clk, ext_rst, busy, go = 1'b0, prst = 1'b0;
  int n_fail = 0, cmp_count = 0, cyc_n = 0, hi;
  eight_bit_match_timer DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_count_clock_in_i(ext_clk), .ext_reset_in_i(ext_rst), .timer_output_pin_o(pin),
    .match_irq_a_o(irq_a), .match_irq_b_o(irq_b), .overflow_irq_o(irq_ovf));
  ext_source_model u_ext (.clk_i(clk_i), .go_i(go), .edges_i(edges), .pulse_rst_i(prst),
    .ext_clk_o(ext_clk), .ext_rst_o(ext_rst), .busy_o(busy));
  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ext(input logic [3:0] n, input logic r);
    edges <= n;
    go <= !r;
    prst <= r;
    @(posedge clk_i);
    go <= 1'b0;
    prst <= 1'b0;
    @(posedge clk_i);
    for (int k = 0; k < 200 && busy; k++) @(posedge clk_i);
    repeat (8) @(posedge clk_i);
  endtask
  task automatic t_reset;
    logic [7:0] exp [7] = '{8'h00, 8'h10, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 8'(4 * i), 8'h00);
      check("reset value", rd, {24'h0, exp[i]});
    end
    check("pin after reset", pin, 1'b0);
  endtask
  task automatic t_match;
    bus(1'b1, 8'h14, 8'h01);
    bus(1'b1, 8'h08, 8'h05);
    bus(1'b1, 8'h04, 8'h02);
    bus(1'b1, 8'h00, 8'h49);
    repeat (40) @(posedge clk_i);
    check("pin high on a", pin, 1'b1);
    check("irq a", {irq_a, irq_b, irq_ovf}, 3'h4);
    bus(1'b1, 8'h00, 8'h48);
    bus(1'b0, 8'h10, 8'h00);
    check("count cleared on a", rd <= 32'h5, 1'b1);
    bus(1'b0, 8'h04, 8'h00);
    check("status", rd, 32'h52);
    bus(1'b1, 8'h04, 8'h42);
    bus(1'b0, 8'h04, 8'h00);
    bus(1'b1, 8'h04, 8'h02);
    bus(1'b0, 8'h04, 8'h00);
    check("flag a cleared", rd, 32'h12);
    check("irq a low", irq_a, 1'b0);
  endtask
  task automatic t_pulse;
    bus(1'b1, 8'h0c, 8'h02);
    bus(1'b1, 8'h08, 8'h09);
    bus(1'b1, 8'h04, 8'h06);
    bus(1'b1, 8'h10, 8'h00);
    bus(1'b1, 8'h00, 8'h09);
    repeat (30) @(posedge clk_i);
    hi = 0;
    repeat (200) @(posedge clk_i) hi += pin;
    check("high cycles per 10 periods", hi, 60);
    bus(1'b1, 8'h0c, 8'h09);
    repeat (30) @(posedge clk_i);
    hi = 0;
    repeat (40) @(posedge clk_i) hi += pin;
    check("high wins over low", hi, 40);
    bus(1'b1, 8'h00, 8'h00);
  endtask
  task automatic t_ext;
    bus(1'b0, 8'h04, 8'h00);
    bus(1'b1, 8'h04, 8'h00);
    bus(1'b1, 8'h10, 8'hfe);
    bus(1'b1, 8'h00, 8'h25);
    ext(4'h6, 1'b0);
    bus(1'b0, 8'h10, 8'h00);
    check("rising count", rd, 32'h01);
    check("irq ovf", irq_ovf, 1'b1);
    bus(1'b0, 8'h04, 8'h00);
    check("overflow flag", rd, 32'h30);
    bus(1'b1, 8'h00, 8'h27);
    bus(1'b1, 8'h10, 8'h00);
    ext(4'h4, 1'b0);
    bus(1'b0, 8'h10, 8'h00);
    check("both edge count", rd, 32'h04);
    bus(1'b1, 8'h00, 8'h3f);
    ext(4'h0, 1'b1);
    bus(1'b0, 8'h10, 8'h00);
    check("ext reset clear", rd, 32'h00);
    bus(1'b0, 8'h04, 8'h00);
    bus(1'b1, 8'h04, 8'h00);
    check("irq ovf cleared", irq_ovf, 1'b0);
  endtask
  initial begin
    forever #5 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_match();
    t_pulse();
    t_ext();
    close_out();
  end
endmodule
